// ### src/fdr_decode_regs.sv
// module: address decoder and runtime control register block
`timescale 1ns/100ps
// Operation
// - decode 256-location control block in I/O space
// - byte DMA sees flash as 128K range
// - overlay window pages eight 16K pages
// - control select for 0000-00FF, I/O only
// - DMA segment n covers n*4000h upward
// - overlay segment n when page equals n
// - peripheral select low for 0200-0207
// - 27 byte registers at fixed offsets
// - all writable registers clear on reset; status registers read live inputs
// - pin-level registers read live pins, read-only
// - output registers stored and read back
// - direction bit 1 means output
// - drive-select registers writable and readable
// - input cell and enable status read-only
// - output cells read state, write loads
// - mask bit 1 blocks cell access
// - sector protection status read-only
// - security status read-only
// - test-port enable writable and readable
// - power and page registers read/write
module fdr_decode_regs (
  input wire logic clk,
  input wire logic rst_n,
  input fdr_pkg::fdr_bus_t bus,
  input wire logic [7:0] port_b_pins,
  input wire logic [7:0] port_c_pins,
  input wire logic [7:0] port_d_pins,
  input wire logic [7:0] port_b_input_cell,
  input wire logic [7:0] port_c_input_cell,
  input wire logic [7:0] port_b_oe_state,
  input wire logic [7:0] port_c_oe_state,
  input wire logic [7:0] port_d_oe_state,
  input wire logic [7:0] output_cell_ab_state,
  input wire logic [7:0] output_cell_bc_state,
  input wire logic [7:0] sector_protect_in,
  input wire logic secure_in,
  output fdr_pkg::fdr_sel_t sel,
  output logic [7:0] rdata,
  output fdr_pkg::fdr_port_t port_b,
  output fdr_pkg::fdr_port_t port_c,
  output fdr_pkg::fdr_port_t port_d,
  output logic [7:0] output_cell_ab_load,
  output logic [7:0] output_cell_bc_load,
  output logic [7:0] output_cell_ab_load_en,
  output logic [7:0] output_cell_bc_load_en,
  output logic [7:0] power_cfg_0,
  output logic [7:0] power_cfg_2,
  output logic test_port_enable,
  output logic [2:0] overlay_page
);
  import fdr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // reset release
  logic rst_meta_q;
  logic rst_sync_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // decode
  function automatic logic in_range(input logic [16:0] a, input logic [16:0] lo, input logic [16:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  logic io_only;
  logic dma_only;
  logic data_only;
  logic ctrl_hit;
  logic [2:0] page_q;
  fdr_sel_t sel_d;
  fdr_sel_t sel_q;

  assign io_only = !bus.io_strobe_n && bus.data_strobe_n && bus.dma_strobe_n;
  assign dma_only = bus.io_strobe_n && bus.data_strobe_n && !bus.dma_strobe_n;
  assign data_only = bus.io_strobe_n && !bus.data_strobe_n && bus.dma_strobe_n;
  assign ctrl_hit = io_only && in_range(bus.addr, CTRL_LO, CTRL_HI);

  generate
    for (genvar n = 0; n < SEG_COUNT; n++) begin : g_seg
      localparam logic [16:0] SEG_LO = 17'(n << SEG_SHIFT);
      localparam logic [16:0] SEG_HI = 17'(((n + 1) << SEG_SHIFT) - 1);
      assign sel_d.flash_segment_select[n] =
        (dma_only && in_range(bus.addr, SEG_LO, SEG_HI)) ||
        (data_only && (page_q == 3'(n)) && in_range(bus.addr, CTRL_LO, WINDOW_HI));
    end
  endgenerate

  assign sel_d.ctrl_select = ctrl_hit;
  assign sel_d.periph_cs_n = !(io_only && in_range(bus.addr, PERIPH_LO, PERIPH_HI));

  // registered outputs: selects appear one clock after the address
  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      sel_q <= '{flash_segment_select: 8'h00, ctrl_select: 1'b0, periph_cs_n: 1'b1};
    end else begin
      sel_q <= sel_d;
    end
  end
  assign sel = sel_q;

  ////////////////////////////////////////////////////////////////////////////
  // register writes
  logic wr_en;
  logic [7:0] ofs;
  fdr_port_t pb_q;
  fdr_port_t pc_q;
  fdr_port_t pd_q;
  logic [7:0] cell_ab_q;
  logic [7:0] cell_bc_q;
  logic [7:0] cell_ab_en_q;
  logic [7:0] cell_bc_en_q;
  logic [7:0] mask_ab_q;
  logic [7:0] mask_bc_q;
  logic [7:0] pwr0_q;
  logic [7:0] pwr2_q;
  logic test_en_q;

  // only the low address byte selects the register
  assign ofs = bus.addr[7:0];
  assign wr_en = ctrl_hit && bus.wr;

  // read-only and unused offsets get no strobe, so such writes drop
  function automatic logic wr_hit(input logic en, input logic [7:0] loc, input logic [7:0] target);
    wr_hit = en && (loc == target);
  endfunction : wr_hit

  logic wr_b_out;
  logic wr_b_dir;
  logic wr_b_drv;
  logic wr_c_out;
  logic wr_c_dir;
  logic wr_c_drv;
  logic wr_d_out;
  logic wr_d_dir;
  logic wr_d_drv;
  logic wr_cell_ab;
  logic wr_cell_bc;
  logic wr_mask_ab;
  logic wr_mask_bc;
  logic wr_pwr0;
  logic wr_pwr2;
  logic wr_test_en;
  logic wr_page;

  assign wr_b_out = wr_hit(wr_en, ofs, OFS_B_OUT);
  assign wr_b_dir = wr_hit(wr_en, ofs, OFS_B_DIR);
  assign wr_b_drv = wr_hit(wr_en, ofs, OFS_B_DRV);
  assign wr_c_out = wr_hit(wr_en, ofs, OFS_C_OUT);
  assign wr_c_dir = wr_hit(wr_en, ofs, OFS_C_DIR);
  assign wr_c_drv = wr_hit(wr_en, ofs, OFS_C_DRV);
  assign wr_d_out = wr_hit(wr_en, ofs, OFS_D_OUT);
  assign wr_d_dir = wr_hit(wr_en, ofs, OFS_D_DIR);
  assign wr_d_drv = wr_hit(wr_en, ofs, OFS_D_DRV);

  assign wr_cell_ab = wr_hit(wr_en, ofs, OFS_CELL_AB);
  assign wr_cell_bc = wr_hit(wr_en, ofs, OFS_CELL_BC);
  assign wr_mask_ab = wr_hit(wr_en, ofs, OFS_MASK_AB);
  assign wr_mask_bc = wr_hit(wr_en, ofs, OFS_MASK_BC);

  assign wr_pwr0 = wr_hit(wr_en, ofs, OFS_PWR0);
  assign wr_pwr2 = wr_hit(wr_en, ofs, OFS_PWR2);
  assign wr_test_en = wr_hit(wr_en, ofs, OFS_TEST_EN);
  assign wr_page = wr_hit(wr_en, ofs, OFS_PAGE);

  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      pb_q <= '{REG_RESET, REG_RESET, REG_RESET};
    end else begin
      if (wr_b_out) begin
        pb_q.out_level <= bus.wdata;
      end
      if (wr_b_dir) begin
        pb_q.direction <= bus.wdata;
      end
      if (wr_b_drv) begin
        pb_q.drive_select <= bus.wdata;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      pc_q <= '{REG_RESET, REG_RESET, REG_RESET};
    end else begin
      if (wr_c_out) begin
        pc_q.out_level <= bus.wdata;
      end
      if (wr_c_dir) begin
        pc_q.direction <= bus.wdata;
      end
      if (wr_c_drv) begin
        pc_q.drive_select <= bus.wdata;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      pd_q <= '{REG_RESET, REG_RESET, REG_RESET};
    end else begin
      if (wr_d_out) begin
        pd_q.out_level <= bus.wdata;
      end
      if (wr_d_dir) begin
        pd_q.direction <= bus.wdata;
      end
      if (wr_d_drv) begin
        pd_q.drive_select <= bus.wdata;
      end
    end
  end

  // bank ab: masked bits keep their value, so a partial load is safe
  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      cell_ab_q <= REG_RESET;
      cell_ab_en_q <= REG_RESET;
    end else begin
      cell_ab_en_q <= wr_cell_ab ? ~mask_ab_q : 8'h00;
      if (wr_cell_ab) begin
        cell_ab_q <= (bus.wdata & ~mask_ab_q) | (cell_ab_q & mask_ab_q);
      end
    end
  end

  // bank bc load, strobe per unmasked bit
  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      cell_bc_q <= REG_RESET;
      cell_bc_en_q <= REG_RESET;
    end else begin
      cell_bc_en_q <= wr_cell_bc ? ~mask_bc_q : 8'h00;
      if (wr_cell_bc) begin
        cell_bc_q <= (bus.wdata & ~mask_bc_q) | (cell_bc_q & mask_bc_q);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      mask_ab_q <= REG_RESET;
      mask_bc_q <= REG_RESET;
    end else begin
      if (wr_mask_ab) begin
        mask_ab_q <= bus.wdata;
      end
      if (wr_mask_bc) begin
        mask_bc_q <= bus.wdata;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      pwr0_q <= REG_RESET;
      pwr2_q <= REG_RESET;
    end else begin
      if (wr_pwr0) begin
        pwr0_q <= bus.wdata;
      end
      if (wr_pwr2) begin
        pwr2_q <= bus.wdata;
      end
    end
  end

  // test-port pin enable, bit 0 only
  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      test_en_q <= 1'b0;
    end else if (wr_test_en) begin
      test_en_q <= bus.wdata[0];
    end
  end

  // page, three bits feed the overlay decoder
  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      page_q <= PAGE_RESET;
    end else if (wr_page) begin
      page_q <= bus.wdata[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read-back
  logic [7:0] rdata_d;
  logic [7:0] rdata_q;
  always_comb begin
    rdata_d = 8'h00;
    case (ofs)
      OFS_B_PIN: rdata_d = port_b_pins;
      OFS_C_PIN: rdata_d = port_c_pins;
      OFS_D_PIN: rdata_d = port_d_pins;
      OFS_B_OUT: rdata_d = pb_q.out_level;
      OFS_C_OUT: rdata_d = pc_q.out_level;
      OFS_D_OUT: rdata_d = pd_q.out_level;
      OFS_B_DIR: rdata_d = pb_q.direction;
      OFS_C_DIR: rdata_d = pc_q.direction;
      OFS_D_DIR: rdata_d = pd_q.direction;
      OFS_B_DRV: rdata_d = pb_q.drive_select;
      OFS_C_DRV: rdata_d = pc_q.drive_select;
      OFS_D_DRV: rdata_d = pd_q.drive_select;
      OFS_B_INC: rdata_d = port_b_input_cell;
      OFS_C_INC: rdata_d = port_c_input_cell;
      OFS_B_OEN: rdata_d = port_b_oe_state;
      OFS_C_OEN: rdata_d = port_c_oe_state;
      OFS_D_OEN: rdata_d = port_d_oe_state;
      // masked cells read as zero
      OFS_CELL_AB: rdata_d = output_cell_ab_state & ~mask_ab_q;
      OFS_CELL_BC: rdata_d = output_cell_bc_state & ~mask_bc_q;
      OFS_MASK_AB: rdata_d = mask_ab_q;
      OFS_MASK_BC: rdata_d = mask_bc_q;
      OFS_PWR0: rdata_d = pwr0_q;
      OFS_PWR2: rdata_d = pwr2_q;
      OFS_PROT: rdata_d = sector_protect_in;
      OFS_SECURE: rdata_d = {7'h00, secure_in};
      OFS_TEST_EN: rdata_d = {7'h00, test_en_q};
      OFS_PAGE: rdata_d = {5'h00, page_q};
      default: rdata_d = 8'h00;
    endcase
  end

  // data held until the next control-block read
  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      rdata_q <= REG_RESET;
    end else if (ctrl_hit && bus.rd) begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata = rdata_q;
  assign port_b = pb_q;
  assign port_c = pc_q;
  assign port_d = pd_q;
  assign output_cell_ab_load = cell_ab_q;
  assign output_cell_bc_load = cell_bc_q;
  assign output_cell_ab_load_en = cell_ab_en_q;
  assign output_cell_bc_load_en = cell_bc_en_q;
  assign power_cfg_0 = pwr0_q;
  assign power_cfg_2 = pwr2_q;
  assign test_port_enable = test_en_q;
  assign overlay_page = page_q;
endmodule : fdr_decode_regs

// ### src/fdr_pkg.sv
// package: constants and carrier types of the flash decode and control register block
package fdr_pkg;
  localparam int unsigned ADDR_W = 17;
  localparam int unsigned CTRL_LOCATIONS = 256;
  localparam logic [16:0] CTRL_LO = 17'h00000;
  localparam logic [16:0] CTRL_HI = 17'h000ff;
  localparam logic [16:0] PERIPH_LO = 17'h00200;
  localparam logic [16:0] PERIPH_HI = 17'h00207;
  localparam logic [16:0] WINDOW_HI = 17'h03fff;
  localparam logic [16:0] DMA_HI = 17'h1ffff;
  localparam int unsigned SEG_COUNT = 8;
  localparam int unsigned SEG_SHIFT = 14;
  // register offsets
  localparam logic [7:0] OFS_B_PIN = 8'h01;
  localparam logic [7:0] OFS_B_OUT = 8'h05;
  localparam logic [7:0] OFS_B_DIR = 8'h07;
  localparam logic [7:0] OFS_B_DRV = 8'h09;
  localparam logic [7:0] OFS_B_INC = 8'h0b;
  localparam logic [7:0] OFS_B_OEN = 8'h0d;
  localparam logic [7:0] OFS_C_PIN = 8'h10;
  localparam logic [7:0] OFS_D_PIN = 8'h11;
  localparam logic [7:0] OFS_C_OUT = 8'h12;
  localparam logic [7:0] OFS_D_OUT = 8'h13;
  localparam logic [7:0] OFS_C_DIR = 8'h14;
  localparam logic [7:0] OFS_D_DIR = 8'h15;
  localparam logic [7:0] OFS_C_DRV = 8'h16;
  localparam logic [7:0] OFS_D_DRV = 8'h17;
  localparam logic [7:0] OFS_C_INC = 8'h18;
  localparam logic [7:0] OFS_C_OEN = 8'h1a;
  localparam logic [7:0] OFS_D_OEN = 8'h1b;
  localparam logic [7:0] OFS_CELL_AB = 8'h20;
  localparam logic [7:0] OFS_CELL_BC = 8'h21;
  localparam logic [7:0] OFS_MASK_AB = 8'h22;
  localparam logic [7:0] OFS_MASK_BC = 8'h23;
  localparam logic [7:0] OFS_PWR0 = 8'hb0;
  localparam logic [7:0] OFS_PWR2 = 8'hb4;
  localparam logic [7:0] OFS_PROT = 8'hc0;
  localparam logic [7:0] OFS_SECURE = 8'hc2;
  localparam logic [7:0] OFS_TEST_EN = 8'hc7;
  localparam logic [7:0] OFS_PAGE = 8'he0;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [2:0] PAGE_RESET = 3'h0;

  // processor bus request, strobes active low
  typedef struct packed {
    logic [16:0] addr;
    logic io_strobe_n;
    logic data_strobe_n;
    logic dma_strobe_n;
    logic rd;
    logic wr;
    logic [7:0] wdata;
  } fdr_bus_t;

  // decoder outputs
  typedef struct packed {
    logic [7:0] flash_segment_select;
    logic ctrl_select;
    logic periph_cs_n;
  } fdr_sel_t;

  // one byte-wide port's pin-facing state
  typedef struct packed {
    logic [7:0] out_level;
    logic [7:0] direction;
    logic [7:0] drive_select;
  } fdr_port_t;
endpackage : fdr_pkg

// ### test/fdr_decode_regs_chk.sv
// checker: decode and register assertions for the flash decode block
`timescale 1ns/100ps
module fdr_decode_regs_chk (
  input wire logic clk,
  input wire logic rst_n,
  input fdr_pkg::fdr_bus_t bus,
  input fdr_pkg::fdr_sel_t sel,
  input wire logic [7:0] rdata,
  input wire logic [7:0] output_cell_ab_load_en,
  input wire logic [7:0] power_cfg_0,
  input wire logic [2:0] overlay_page
);
  import fdr_pkg::*;
  logic io_c, ctl_c, per_c, dma_c, ovl_c, cab_w;
  logic [7:0] dma_seg, ovl_seg;
  assign io_c = !bus.io_strobe_n && bus.data_strobe_n && bus.dma_strobe_n;
  assign ctl_c = io_c && bus.addr <= CTRL_HI;
  assign per_c = io_c && bus.addr >= PERIPH_LO && bus.addr <= PERIPH_HI;
  assign dma_c = bus.io_strobe_n && bus.data_strobe_n && !bus.dma_strobe_n;
  assign ovl_c = bus.io_strobe_n && !bus.data_strobe_n && bus.dma_strobe_n && bus.addr <= WINDOW_HI;
  assign cab_w = ctl_c && bus.wr && bus.addr[7:0] == OFS_CELL_AB;
  assign dma_seg = 8'h01 << bus.addr[16:14];
  assign ovl_seg = 8'h01 << overlay_page;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_wr(logic [7:0] ofs);
    ctl_c && bus.wr && bus.addr[7:0] == ofs;
  endsequence
  //////////////////////////////////////////////////////////////////////////
  chk_ctrl_sel_on: assert property (ctl_c |=> sel.ctrl_select) else $error("ctrl select missing");
  chk_ctrl_sel_off: assert property (!ctl_c |=> !sel.ctrl_select) else $error("ctrl select stray");
  chk_periph_cs_on: assert property (per_c |=> !sel.periph_cs_n) else $error("periph select missing");
  chk_periph_cs_off: assert property (!per_c |=> sel.periph_cs_n) else $error("periph select stray");
  chk_dma_seg_map: assert property (dma_c |=> sel.flash_segment_select == $past(dma_seg))
    else $error("dma segment wrong");
  chk_ovl_seg_map: assert property (ovl_c |=> sel.flash_segment_select == $past(ovl_seg))
    else $error("overlay segment wrong");
  chk_no_seg_sel: assert property (!dma_c && !ovl_c |=> sel.flash_segment_select == 8'h00)
    else $error("segment stray");
  chk_page_reg_load: assert property (s_wr(OFS_PAGE) |=> {5'h00, overlay_page} == ($past(bus.wdata) & 8'h07))
    else $error("page not loaded");
  chk_power_reg_load: assert property (s_wr(OFS_PWR0) |=> power_cfg_0 == $past(bus.wdata))
    else $error("power cfg not loaded");
  chk_cell_load_cause: assert property (output_cell_ab_load_en != 8'h00 |-> $past(cab_w))
    else $error("cell load without write");
  chk_rdata_hold: assert property (!(ctl_c && bus.rd) |=> $stable(rdata)) else $error("rdata moved");
endmodule : fdr_decode_regs_chk
//////////////////////////////////////////////////////////////////////////
bind fdr_decode_regs fdr_decode_regs_chk u_fdr_decode_regs_chk (.clk(clk), .rst_n(rst_n), .bus(bus), .sel(sel),
  .rdata(rdata), .output_cell_ab_load_en(output_cell_ab_load_en), .power_cfg_0(power_cfg_0),
  .overlay_page(overlay_page));

// ### test/fdr_host_model.sv
// partner: host processor driving the byte-wide bus
`timescale 1ns/100ps
module fdr_host_model (
  input wire logic clk,
  output fdr_pkg::fdr_bus_t bus,
  input wire logic [7:0] rdata
);
  import fdr_pkg::*;
  initial bus = {17'h1ffff, 3'h7, 2'h0, 8'hff};
  //////////////////////////////////////////////////////////////////////////
  // byte only, mapped offsets
  // released lines show inverted values so stale data never looks valid
  task automatic acc(input logic [2:0] stb_n, input logic [16:0] a, input logic w, input logic [7:0] d,
    output logic [7:0] q);
    @(negedge clk);
    bus = {a, stb_n, !w, w, d};
    @(negedge clk);
    q = rdata;
    bus = {~a, 3'h7, 2'h0, ~d};
  endtask : acc
endmodule : fdr_host_model

// ### test/test_dsp_flash_decode_regs.sv
// testbench: decode map and control registers of the flash decode block
`timescale 1ns/100ps
module test_dsp_flash_decode_regs;
  import fdr_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic secure = 1'b1;
  logic [7:0] st [11];
  logic [7:0] q, rdata, cab_load, cab_en, cbc_load, cbc_en, pwr0, pwr2;
  logic tpe;
  logic [2:0] opage;
  fdr_bus_t bus;
  fdr_sel_t sel;
  fdr_port_t port_b, port_c, port_d;
  int fail_count = 0;
  int checks_done = 0;
  logic [7:0] ro_ofs [11] = '{8'h01, 8'h10, 8'h11, 8'h0b, 8'h18, 8'h0d, 8'h1a, 8'h1b, 8'h20, 8'h21, 8'hc0};
  logic [7:0] rw_ofs [15] = '{8'h05, 8'h07, 8'h09, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h22, 8'h23,
    8'hb0, 8'hb4, 8'he0, 8'hc7};
  fdr_decode_regs u_fdr_decode_regs (.clk(clk), .rst_n(rst_n), .bus(bus), .port_b_pins(st[0]),
    .port_c_pins(st[1]), .port_d_pins(st[2]), .port_b_input_cell(st[3]), .port_c_input_cell(st[4]),
    .port_b_oe_state(st[5]), .port_c_oe_state(st[6]), .port_d_oe_state(st[7]), .output_cell_ab_state(st[8]),
    .output_cell_bc_state(st[9]), .sector_protect_in(st[10]), .secure_in(secure), .sel(sel), .rdata(rdata),
    .port_b(port_b), .port_c(port_c), .port_d(port_d), .output_cell_ab_load(cab_load),
    .output_cell_bc_load(cbc_load), .output_cell_ab_load_en(cab_en), .output_cell_bc_load_en(cbc_en),
    .power_cfg_0(pwr0), .power_cfg_2(pwr2), .test_port_enable(tpe), .overlay_page(opage));
  fdr_host_model u_fdr_host_model (.clk(clk), .bus(bus), .rdata(rdata));
  always #4 clk = ~clk;
  //////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    checks_done++;
    if (seen !== want) begin
      fail_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask : check
  task automatic io(input logic [7:0] ofs, input logic w, input logic [7:0] d);
    u_fdr_host_model.acc(3'b011, {9'h000, ofs}, w, d, q);
  endtask : io
  task automatic dec(input logic [2:0] s, input logic [16:0] a, input logic [7:0] seg, input logic [1:0] cs);
    u_fdr_host_model.acc(s, a, 1'b0, 8'h00, q);
    check(sel.flash_segment_select, seg);
    check({6'h00, sel.ctrl_select, sel.periph_cs_n}, {6'h00, cs});
  endtask : dec
  task automatic give_verdict();
    if (fail_count == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict
  //////////////////////////////////////////////////////////////////////////
  // reset, status, writes ignored
  task automatic t_status();
    foreach (ro_ofs[i]) begin
      io(ro_ofs[i], 1'b0, 8'h00);
      check(q, st[i]);
      if (i < 8 || i == 10) io(ro_ofs[i], 1'b1, 8'hff);
      io(ro_ofs[i], 1'b0, 8'h00);
      check(q, st[i]);
    end
    // read-only writes above must not have reached any writable register
    foreach (rw_ofs[i]) begin
      io(rw_ofs[i], 1'b0, 8'h00);
      check(q, 8'h00);
    end
    io(8'hc2, 1'b0, 8'h00);
    check(q, 8'h01);
    io(8'h02, 1'b0, 8'h00);
    check(q, 8'h00);
  endtask : t_status
  task automatic t_rw();
    logic [7:0] m;
    foreach (rw_ofs[i]) begin
      m = (i == 13) ? 8'h07 : (i == 14) ? 8'h01 : 8'hff;
      io(rw_ofs[i], 1'b1, rw_ofs[i] ^ 8'ha5);
      io(rw_ofs[i], 1'b0, 8'h00);
      check(q, (rw_ofs[i] ^ 8'ha5) & m);
      if (i == 11) check(pwr0, 8'h15);
      if (i == 12) check(pwr2, 8'h11);
      if (i == 13) check({5'h00, opage}, 8'h05);
      if (i > 8) io(rw_ofs[i], 1'b1, 8'h00);
    end
    check(port_b.out_level, 8'ha0);
    check(port_b.direction, 8'ha2);
    check(port_b.drive_select, 8'hac);
    check(port_c.out_level, 8'hb7);
    check(port_c.direction, 8'hb1);
    check(port_c.drive_select, 8'hb3);
    check(port_d.out_level, 8'hb6);
    check(port_d.direction, 8'hb0);
    check(port_d.drive_select, 8'hb2);
    io(8'hc7, 1'b1, 8'h01);
    io(8'hc7, 1'b0, 8'h00);
    check(q, 8'h01);
    check({7'h00, tpe}, 8'h01);
    io(8'hc7, 1'b1, 8'h00);
  endtask : t_rw
  task automatic t_cells();
    logic [7:0] k;
    for (int b = 0; b < 2; b++) begin
      k = b ? 8'hf0 : 8'h0f;
      io(8'h22 + 8'(b), 1'b1, k);
      io(8'h20 + 8'(b), 1'b0, 8'h00);
      check(q, st[8 + b] & ~k);
      io(8'h20 + 8'(b), 1'b1, 8'hff);
      check(b ? cbc_en : cab_en, ~k);
      check(b ? cbc_load : cab_load, ~k);
      @(negedge clk);
      check(b ? cbc_en : cab_en, 8'h00);
      io(8'h22 + 8'(b), 1'b1, 8'h00);
    end
  endtask : t_cells
  task automatic t_decode();
    for (int n = 0; n < 8; n++) begin
      dec(3'b110, 17'(n << 14), 8'h01 << n, 2'b01);
      dec(3'b110, 17'((n << 14) | 16'h3fff), 8'h01 << n, 2'b01);
      io(8'he0, 1'b1, 8'(n));
      dec(3'b101, 17'h03fff, 8'h01 << n, 2'b01);
    end
    dec(3'b101, 17'h04000, 8'h00, 2'b01);
    dec(3'b011, 17'h000ff, 8'h00, 2'b11);
    dec(3'b011, 17'h00100, 8'h00, 2'b01);
    dec(3'b011, 17'h00200, 8'h00, 2'b00);
    dec(3'b011, 17'h00207, 8'h00, 2'b00);
    dec(3'b011, 17'h00208, 8'h00, 2'b01);
    dec(3'b010, 17'h00000, 8'h00, 2'b01);
  endtask : t_decode
  //////////////////////////////////////////////////////////////////////////
  initial begin
    for (int i = 0; i < 11; i++) st[i] = 8'(8'h27 * (i + 1));
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(posedge clk);
    t_status();
    t_rw();
    t_cells();
    t_decode();
    give_verdict();
  end
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    give_verdict();
  end
endmodule : test_dsp_flash_decode_regs
